// >>> design/mir_irq_route.sv
// enable gating and two-pin routing of the motion detector outputs
// detectors are on the same clock; hold-time counting is outside
// Operation
// - enable-one bits 6,5,4 enable watermark, queue-full and sample-ready; bit 7 reads back as written.
// - enable-one bit 3 enables freefall and bits 2..0 enable shock z, y and x.
// - enable-two bits 2..0 enable stillness z, y and x; bits 7..4 are reserved.
// - enable-two bit 3 picks slow-motion at 0 and no-motion at 1.
// - pin-a route bits 7..4 send level, tilt, single and double knock to pin a.
// - pin-a route bits 3..0 send stillness, anymotion, shock and freefall to pin a.
// - shared route bits 0,1,2 send sample-ready, watermark and queue-full to pin a.
// - shared route bits 7,6,5 send them to pin b; bits 4 and 3 are reserved.
// - pin-b route bits 7..4 send level, tilt, single and double knock to pin b.
// - pin-b route bits 3..0 send stillness, anymotion, shock and freefall to pin b.
// - an enable-zero register enables level, tilt, knocks and per-axis anymotion.
// - writing one to the reset bit clears held interrupts; codes 0111b and 1111b latch.
// - each pin has polarity and drive select, both reset to active-high push-pull.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps

module mir_irq_route (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic [7:0]       addr,
    input  wire logic [7:0]       wdata,
    input  wire logic             wr_stb,
    input  wire logic             rd_stb,
    output logic      [7:0]       rdata,
    input  wire mir_pkg::mir_det_t det,
    output logic                  still_mode_sel,
    output logic                  irq_pin_a_o,
    output logic                  irq_pin_a_oe,
    output logic                  irq_pin_b_o,
    output logic                  irq_pin_b_oe,
    output logic                  irq_out
);

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [7:0] en0_r, en0_nxt;
    logic [7:0] en1_r, en1_nxt;
    logic [7:0] en2_r, en2_nxt;
    logic [7:0] rta_r, rta_nxt;
    logic [7:0] rts_r, rts_nxt;
    logic [7:0] rtb_r, rtb_nxt;
    logic [7:0] pinc_r, pinc_nxt;
    logic [3:0] latch_r, latch_nxt;
    logic [1:0] sts_r, sts_nxt;
    logic [1:0] msk_r, msk_nxt;
    logic [7:0] rdata_nxt;
    logic       clr_held;

    // gated pin sources
    logic [7:0] mot_fire;
    logic       act_a, act_b;
    logic       held_a_r, held_a_nxt, held_b_r, held_b_nxt;
    logic       lvl_a, lvl_b;
    mir_pkg::mir_pin_t pa_nxt, pb_nxt;
    logic       irq_nxt;
    logic       hold_mode;

    always_comb begin
        en0_nxt   = en0_r;
        en1_nxt   = en1_r;
        en2_nxt   = en2_r;
        rta_nxt   = rta_r;
        rts_nxt   = rts_r;
        rtb_nxt   = rtb_r;
        pinc_nxt  = pinc_r;
        latch_nxt = latch_r;
        msk_nxt   = msk_r;
        clr_held  = 1'b0;
        rdata_nxt = 8'h00;
        if (wr_stb) begin
            case (addr)
                mir_pkg::OFS_EN_GROUP_ZERO: en0_nxt  = wdata;
                mir_pkg::OFS_EN_GROUP_ONE:  en1_nxt  = wdata;
                mir_pkg::OFS_EN_GROUP_TWO:  en2_nxt  = wdata;
                mir_pkg::OFS_PIN_A_ROUTE:   rta_nxt  = wdata;
                mir_pkg::OFS_SHARED_ROUTE:  rts_nxt  = wdata;
                mir_pkg::OFS_PIN_B_ROUTE:   rtb_nxt  = wdata;
                mir_pkg::OFS_PIN_CTRL:      pinc_nxt = wdata;
                mir_pkg::OFS_LATCH_CTRL: begin
                    latch_nxt = wdata[3:0];
                    clr_held  = wdata[mir_pkg::POS_RESET_INT];
                end
                mir_pkg::OFS_EVT_MASK:      msk_nxt  = wdata[1:0];
                default: ;
            endcase
        end
        if (rd_stb) begin
            case (addr)
                mir_pkg::OFS_EN_GROUP_ZERO: rdata_nxt = en0_r;
                mir_pkg::OFS_EN_GROUP_ONE:  rdata_nxt = en1_r;
                mir_pkg::OFS_EN_GROUP_TWO:  rdata_nxt = en2_r;
                mir_pkg::OFS_PIN_A_ROUTE:   rdata_nxt = rta_r;
                mir_pkg::OFS_SHARED_ROUTE:  rdata_nxt = rts_r;
                mir_pkg::OFS_PIN_B_ROUTE:   rdata_nxt = rtb_r;
                mir_pkg::OFS_PIN_CTRL:      rdata_nxt = pinc_r;
                mir_pkg::OFS_LATCH_CTRL:    rdata_nxt = {4'h0, latch_r};
                mir_pkg::OFS_EVT_STATUS:    rdata_nxt = {6'h00, sts_r};
                mir_pkg::OFS_EVT_MASK:      rdata_nxt = {6'h00, msk_r};
                default:                    rdata_nxt = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // enable gating and routing
    // ------------------------------------------------------------
    always_comb begin
        mot_fire = 8'h00;
        mot_fire[mir_pkg::RT_LOW]   = det.freefall & en1_r[mir_pkg::POS_LOW_EN];
        mot_fire[mir_pkg::RT_HIGH]  = |(det.shock & en1_r[2:0]);
        mot_fire[mir_pkg::RT_SLOPE] = |(det.anymotion & en0_r[2:0]);
        mot_fire[mir_pkg::RT_DTAP]  = det.double_knock & en0_r[4];
        mot_fire[mir_pkg::RT_STAP]  = det.single_knock & en0_r[5];
        mot_fire[mir_pkg::RT_TILT]  = det.tilt & en0_r[6];
        mot_fire[mir_pkg::RT_LEVEL] = det.level & en0_r[7];
        mot_fire[mir_pkg::RT_STILL] = |(det.stillness & en2_r[2:0]);
    end

    // or of enabled and routed sources
    always_comb begin
        act_a = |(mot_fire & rta_r);
        act_b = |(mot_fire & rtb_r);
        // fifo and data to pin a
        act_a = act_a
              | (det.sample_ready & en1_r[mir_pkg::POS_DATA_EN] & rts_r[mir_pkg::POS_A_DATA])
              | (det.watermark & en1_r[mir_pkg::POS_FWM_EN] & rts_r[mir_pkg::POS_A_FWM])
              | (det.queue_full & en1_r[mir_pkg::POS_FFULL_EN] & rts_r[mir_pkg::POS_A_FFULL]);
        // fifo and data to pin b
        act_b = act_b
              | (det.sample_ready & en1_r[mir_pkg::POS_DATA_EN] & rts_r[mir_pkg::POS_B_DATA])
              | (det.watermark & en1_r[mir_pkg::POS_FWM_EN] & rts_r[mir_pkg::POS_B_FWM])
              | (det.queue_full & en1_r[mir_pkg::POS_FFULL_EN] & rts_r[mir_pkg::POS_B_FFULL]);
    end

    // ------------------------------------------------------------
    // latching, polarity, drive
    // ------------------------------------------------------------
    always_comb begin
        // latched modes hold until cleared; timed modes act as non-latched here
        hold_mode  = (latch_r == mir_pkg::LATCH_HOLD_A) || (latch_r == mir_pkg::LATCH_HOLD_B);
        held_a_nxt = hold_mode & ((held_a_r & ~clr_held) | act_a);
        held_b_nxt = hold_mode & ((held_b_r & ~clr_held) | act_b);
        lvl_a      = act_a | held_a_r;
        lvl_b      = act_b | held_b_r;
        pa_nxt.level = pinc_r[mir_pkg::POS_A_POLARITY] ? lvl_a : ~lvl_a;
        pb_nxt.level = pinc_r[mir_pkg::POS_B_POLARITY] ? lvl_b : ~lvl_b;
        pa_nxt.o     = pinc_r[mir_pkg::POS_A_DRIVE] ? 1'b0 : pa_nxt.level;
        pa_nxt.oe    = pinc_r[mir_pkg::POS_A_DRIVE] ? ~pa_nxt.level : 1'b1;
        pb_nxt.o     = pinc_r[mir_pkg::POS_B_DRIVE] ? 1'b0 : pb_nxt.level;
        pb_nxt.oe    = pinc_r[mir_pkg::POS_B_DRIVE] ? ~pb_nxt.level : 1'b1;
        // set beats write-one clear
        sts_nxt = sts_r;
        if (wr_stb && addr == mir_pkg::OFS_EVT_STATUS)
            sts_nxt = sts_r & ~wdata[1:0];
        sts_nxt = sts_nxt | {lvl_b, lvl_a};
        // a mask bit of one silences its status bit
        irq_nxt = |(sts_nxt & ~msk_nxt);
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            en0_r        <= mir_pkg::RST_ZERO;
            en1_r        <= mir_pkg::RST_ZERO;
            en2_r        <= mir_pkg::RST_ZERO;
            rta_r        <= mir_pkg::RST_ZERO;
            rts_r        <= mir_pkg::RST_ZERO;
            rtb_r        <= mir_pkg::RST_ZERO;
            pinc_r       <= mir_pkg::RST_PIN_CTRL;
            latch_r      <= 4'h0;
            sts_r        <= 2'h0;
            msk_r        <= 2'h0;
            held_a_r     <= 1'b0;
            held_b_r     <= 1'b0;
            rdata        <= 8'h00;
            still_mode_sel <= 1'b0;
            irq_pin_a_o  <= 1'b0;
            irq_pin_a_oe <= 1'b1;
            irq_pin_b_o  <= 1'b0;
            irq_pin_b_oe <= 1'b1;
            irq_out      <= 1'b0;
        end else begin
            en0_r        <= en0_nxt;
            en1_r        <= en1_nxt;
            en2_r        <= en2_nxt;
            rta_r        <= rta_nxt;
            rts_r        <= rts_nxt;
            rtb_r        <= rtb_nxt;
            pinc_r       <= pinc_nxt;
            latch_r      <= latch_nxt;
            sts_r        <= sts_nxt;
            msk_r        <= msk_nxt;
            held_a_r     <= held_a_nxt;
            held_b_r     <= held_b_nxt;
            rdata        <= rdata_nxt;
            still_mode_sel <= en2_nxt[mir_pkg::POS_STILL_SEL];
            irq_pin_a_o  <= pa_nxt.o;
            irq_pin_a_oe <= pa_nxt.oe;
            irq_pin_b_o  <= pb_nxt.o;
            irq_pin_b_oe <= pb_nxt.oe;
            irq_out      <= irq_nxt;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_EN1_READBACK: assert property (@(posedge clk) disable iff (!rstn)
        wr_stb && addr == mir_pkg::OFS_EN_GROUP_ONE ##1 !wr_stb ##1 rd_stb && addr == mir_pkg::OFS_EN_GROUP_ONE
        |=> rdata == $past(wdata, 3)) else $error("enable-one readback wrong");
    AST_FREEFALL_OFF: assert property (@(posedge clk) disable iff (!rstn)
        !en1_r[mir_pkg::POS_LOW_EN] |-> !mot_fire[mir_pkg::RT_LOW]) else $error("freefall passed while off");
    AST_STILL_GATE: assert property (@(posedge clk) disable iff (!rstn)
        en2_r[2:0] == 3'h0 |-> !mot_fire[mir_pkg::RT_STILL]) else $error("stillness passed while off");
    AST_STILL_SEL: assert property (@(posedge clk) disable iff (!rstn)
        ##1 still_mode_sel == $past(en2_nxt[mir_pkg::POS_STILL_SEL])) else $error("mode select lags");
    AST_PIN_A_ROUTE: assert property (@(posedge clk) disable iff (!rstn)
        (rta_r & mot_fire) != 8'h00 |=> irq_pin_a_o == $past(pinc_r[mir_pkg::POS_A_POLARITY])
        || $past(pinc_r[mir_pkg::POS_A_DRIVE])) else $error("pin a not asserted");
    AST_PIN_B_ROUTE: assert property (@(posedge clk) disable iff (!rstn)
        (rtb_r & mot_fire) != 8'h00 |=> irq_pin_b_o == $past(pinc_r[mir_pkg::POS_B_POLARITY])
        || $past(pinc_r[mir_pkg::POS_B_DRIVE])) else $error("pin b not asserted");
    AST_SHARED_A: assert property (@(posedge clk) disable iff (!rstn)
        det.sample_ready && en1_r[mir_pkg::POS_DATA_EN] && rts_r[mir_pkg::POS_A_DATA] |-> act_a)
        else $error("sample ready lost to pin a");
    AST_SHARED_B: assert property (@(posedge clk) disable iff (!rstn)
        det.queue_full && en1_r[mir_pkg::POS_FFULL_EN] && rts_r[mir_pkg::POS_B_FFULL] |-> act_b)
        else $error("queue full lost to pin b");
    AST_NO_SOURCE: assert property (@(posedge clk) disable iff (!rstn)
        !act_a && !held_a_r && !pinc_r[mir_pkg::POS_A_DRIVE] |=> irq_pin_a_o == !$past(pinc_r[0]))
        else $error("pin a active without source");
    AST_HOLD_CLEAR: assert property (@(posedge clk) disable iff (!rstn)
        clr_held && !act_a |=> !held_a_r) else $error("held interrupt not cleared");

endmodule

// >>> design/mir_pkg.sv
// package for the motion interrupt enable and pin routing block
// assumes one 200 MHz clock and a simple strobe register port
package mir_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_EN_GROUP_ZERO  = 8'h16;
    localparam logic [7:0] OFS_EN_GROUP_ONE   = 8'h17;
    localparam logic [7:0] OFS_EN_GROUP_TWO   = 8'h18;
    localparam logic [7:0] OFS_PIN_A_ROUTE    = 8'h19;
    localparam logic [7:0] OFS_SHARED_ROUTE   = 8'h1a;
    localparam logic [7:0] OFS_PIN_B_ROUTE    = 8'h1b;
    localparam logic [7:0] OFS_PIN_CTRL       = 8'h20;
    localparam logic [7:0] OFS_LATCH_CTRL     = 8'h21;
    localparam logic [7:0] OFS_EVT_STATUS     = 8'h30;
    localparam logic [7:0] OFS_EVT_MASK       = 8'h31;

    // ------------------------------------------------------------
    // reset values and reserved bit masks
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ZERO           = 8'h00;
    localparam logic [7:0] RST_PIN_CTRL       = 8'h05;
    localparam logic [7:0] RESERVED_EN_TWO    = 8'hf0;
    localparam logic [7:0] RESERVED_SHARED    = 8'h18;
    localparam logic [7:0] RESERVED_EN_ZERO   = 8'h08;
    localparam logic [7:0] RESERVED_PIN_CTRL  = 8'hf0;
    localparam logic [7:0] RESERVED_LATCH     = 8'h70;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int POS_FWM_EN        = 6;
    localparam int POS_FFULL_EN      = 5;
    localparam int POS_DATA_EN       = 4;
    localparam int POS_LOW_EN        = 3;
    localparam int POS_STILL_SEL     = 3;
    localparam int POS_A_DATA        = 0;
    localparam int POS_A_FWM         = 1;
    localparam int POS_A_FFULL       = 2;
    localparam int POS_B_DATA        = 7;
    localparam int POS_B_FWM         = 6;
    localparam int POS_B_FFULL       = 5;
    localparam int POS_A_POLARITY    = 0;
    localparam int POS_A_DRIVE       = 1;
    localparam int POS_B_POLARITY    = 2;
    localparam int POS_B_DRIVE       = 3;
    localparam int POS_RESET_INT     = 7;
    localparam logic [3:0] LATCH_HOLD_A = 4'h7;
    localparam logic [3:0] LATCH_HOLD_B = 4'hf;

    // motion route bit order, shared by both pin route registers
    localparam int RT_LOW   = 0;
    localparam int RT_HIGH  = 1;
    localparam int RT_SLOPE = 2;
    localparam int RT_STILL = 3;
    localparam int RT_DTAP  = 4;
    localparam int RT_STAP  = 5;
    localparam int RT_TILT  = 6;
    localparam int RT_LEVEL = 7;

    typedef struct packed {
        logic       level;
        logic       tilt;
        logic       single_knock;
        logic       double_knock;
        logic [2:0] anymotion;
        logic [2:0] shock;
        logic       freefall;
        logic [2:0] stillness;
        logic       sample_ready;
        logic       watermark;
        logic       queue_full;
    } mir_det_t;

    typedef struct packed {
        logic       level;
        logic       o;
        logic       oe;
    } mir_pin_t;

endpackage

// >>> bench/mir_host_model.sv
// host side of the two interrupt pins: resolves each wire and reads it
// assumes a board pull-up on both lines, which open drain relies on
`timescale 1ns/1ps

module mir_host_model (
    input  wire logic pin_a_o,
    input  wire logic pin_a_oe,
    input  wire logic pin_b_o,
    input  wire logic pin_b_oe,
    input  wire logic pin_a_polarity,
    input  wire logic pin_b_polarity,
    output logic      wire_a,
    output logic      wire_b,
    output logic      seen_a,
    output logic      seen_b
);
    // ------------------------------------------------------------
    // wire level and active reading
    // ------------------------------------------------------------
    // a released line floats to the pull-up, never to the last value
    assign wire_a = pin_a_oe ? pin_a_o : 1'b1;
    assign wire_b = pin_b_oe ? pin_b_o : 1'b1;
    assign seen_a = (wire_a === pin_a_polarity);
    assign seen_b = (wire_b === pin_b_polarity);
endmodule

// >>> bench/tb.sv
// self-checking bench for the interrupt enable and pin routing block
// assumes the strobe register port and one-cycle pin latency
`timescale 1ns/1ps

module tb;
    logic                         clk = 1'b0;
    logic                         rstn = 1'b0;
    logic                         wr_stb = 1'b0;
    logic                         rd_stb = 1'b0;
    logic [7:0]                   addr = 8'h00;
    logic [7:0]                   wdata = 8'h00;
    logic [7:0]                   rdata;
    mir_pkg::mir_det_t            det = '0;
    logic [$bits(det)-1:0]        dv;
    logic                         still_mode_sel, pa_o, pa_oe, pb_o, pb_oe, irq_out;
    logic                         wa, wb, sa, sb;
    logic                         pol_a = 1'b1;
    logic                         pol_b = 1'b1;
    logic [7:0]                   ra, rb;
    int                           mismatches = 0;
    int                           num_checks = 0;
    // per detector: enable offset, enable bit, pin a route bit, pin b route bit
    logic [7:0] en_o [17] = '{8'h17, 8'h17, 8'h17, 8'h18, 8'h18, 8'h18, 8'h17, 8'h17, 8'h17,
                              8'h17, 8'h16, 8'h16, 8'h16, 8'h16, 8'h16, 8'h16, 8'h16};
    int en_b [17] = '{5, 6, 4, 0, 1, 2, 3, 0, 1, 2, 0, 1, 2, 4, 5, 6, 7};
    int rt_a [17] = '{2, 1, 0, 3, 3, 3, 0, 1, 1, 1, 2, 2, 2, 4, 5, 6, 7};
    int rt_b [17] = '{5, 6, 7, 3, 3, 3, 0, 1, 1, 1, 2, 2, 2, 4, 5, 6, 7};

    always #2.5 clk = ~clk;

    mir_irq_route mir_irq_route_i (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .det(det), .still_mode_sel(still_mode_sel), .irq_pin_a_o(pa_o),
        .irq_pin_a_oe(pa_oe), .irq_pin_b_o(pb_o), .irq_pin_b_oe(pb_oe), .irq_out(irq_out));
    mir_host_model mir_host_model_i (.pin_a_o(pa_o), .pin_a_oe(pa_oe), .pin_b_o(pb_o), .pin_b_oe(pb_oe),
        .pin_a_polarity(pol_a), .pin_b_polarity(pol_b), .wire_a(wa), .wire_b(wb), .seen_a(sa), .seen_b(sb));

    // ------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // host keeps reserved bits zero except where readback is probed
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #100000;
        mismatches++;
        conclude();
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        for (int o = 8'h16; o <= 8'h1b; o++) rd(8'(o), 8'h00);
        rd(8'h20, 8'h05);
        rd(8'h40, 8'h00);
        wr(8'h17, 8'h80);
        rd(8'h17, 8'h80);
        wr(8'h17, 8'h00);
        wr(8'h18, 8'h08);
        waitc(2);
        chk({7'h0, still_mode_sel}, 8'h01);
        rd(8'h18, 8'h08);
        wr(8'h18, 8'h00);
        waitc(2);
        chk({7'h0, still_mode_sel}, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 17; i++) begin
            ra = (i < 3) ? 8'h1a : 8'h19;
            rb = (i < 3) ? 8'h1a : 8'h1b;
            dv = 1 << i;
            wr(en_o[i], 8'h01 << en_b[i]);
            wr(ra, 8'h01 << rt_a[i]);
            det <= dv;
            waitc(3);
            chk({6'h0, sa, sb}, 8'h02);
            wr(ra, 8'h00);
            wr(rb, 8'h01 << rt_b[i]);
            waitc(3);
            chk({6'h0, sa, sb}, 8'h01);
            wr(en_o[i], 8'h00);
            waitc(3);
            chk({6'h0, sa, sb}, 8'h00);
            wr(rb, 8'h00);
            det <= '0;
        end
        $display("test routing done");
        wr(8'h30, 8'h03);
        rd(8'h30, 8'h00);
        chk({7'h0, irq_out}, 8'h00);
        // pin a active low open drain: idle means released
        wr(8'h20, 8'h06);
        pol_a <= 1'b0;
        waitc(3);
        chk({6'h0, pa_oe, sa}, 8'h00);
        wr(8'h17, 8'h10);
        wr(8'h1a, 8'h01);
        for (int k = 0; k < 2; k++) begin
            wr(8'h21, k ? 8'h0f : 8'h07);
            det.sample_ready <= 1'b1;
            waitc(3);
            chk({5'h0, pa_oe, wa, sa}, 8'h05);
            det.sample_ready <= 1'b0;
            waitc(4);
            chk({7'h0, sa}, 8'h01);
            wr(8'h21, 8'h80);
            waitc(3);
            chk({7'h0, sa}, 8'h00);
        end
        $display("test polarity and latch done");
        rd(8'h30, 8'h01);
        chk({7'h0, irq_out}, 8'h01);
        wr(8'h31, 8'h01);
        waitc(3);
        chk({7'h0, irq_out}, 8'h00);
        wr(8'h31, 8'h00);
        wr(8'h30, 8'h01);
        waitc(3);
        rd(8'h30, 8'h00);
        chk({7'h0, irq_out}, 8'h00);
        $display("test interrupt done");
        conclude();
    end
endmodule
